/* inc/misc_ctrl_pkg.sv */
// Constants, field positions and state encodings for the sensor miscellaneous control block
package misc_ctrl_pkg;

    // Register offsets on the serial register port
    localparam logic [7:0] ADDR_INIT3 = 8'h1A;
    localparam logic [7:0] ADDR_SPARE = 8'h1B;
    localparam logic [7:0] ADDR_POWER = 8'h1C;
    localparam logic [7:0] ADDR_XDRV = 8'h20;
    localparam logic [7:0] ADDR_YDRV = 8'h21;
    localparam logic [7:0] ADDR_ZDRV = 8'h22;
    localparam logic [7:0] ADDR_RESTART = 8'h24;

    // Reset values
    localparam logic [7:0] REG_RESET = 8'h00;
    localparam logic [2:0] LVL_RESET = 3'h0;

    // Field positions
    localparam int ACTIVE_LVL_LSB = 0;
    localparam int WATCH_LVL_LSB = 4;
    localparam int LVL_W = 3;
    localparam int BIT_FAST = 7;
    localparam int BIT_PUSH_POS = 2;
    localparam int BIT_PUSH_NEG = 3;
    localparam int BIT_Y_ACTIVE = 7;
    localparam int BIT_RESTART = 6;
    localparam int BIT_RELOAD = 7;

    // Power level codes
    localparam logic [2:0] PWR_LOW = 3'h0;
    localparam logic [2:0] PWR_ULTRA = 3'h3;
    localparam logic [2:0] PWR_PRECISE = 3'h4;

    // Operating mode codes that read Y drive bit 7 as zero
    localparam logic [2:0] OP_SLEEP = 3'h0;
    localparam logic [2:0] OP_STANDBY = 3'h1;

    // Fuse array timing
    localparam int CLK_PERIOD_NS = 100;
    localparam int FUSE_SETTLE_NS = 1000;
    localparam int FUSE_SETTLE_CYC = (FUSE_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int FUSE_WORDS = 32;
    localparam int FUSE_AW = 5;
    localparam int FUSE_DW = 8;

    // Restart sequencer states, Gray along the restart path
    typedef enum logic [1:0] {
        RS_IDLE = 2'h0,
        RS_DEFAULTS = 2'h1,
        RS_FUSE = 2'h3,
        RS_EXPAND = 2'h2
    } restart_state_e;

    // Fuse loader states, Gray along the path
    typedef enum logic [1:0] {
        FS_OFF = 2'h0,
        FS_SETTLE = 2'h1,
        FS_READ = 2'h3,
        FS_DOWN = 2'h2
    } fuse_state_e;

endpackage : misc_ctrl_pkg

/* inc/fuse_seq_if.sv */
// Link between the restart control and the fuse loader
`timescale 1ns/100ps
interface fuse_seq_if #(
    parameter int AW = misc_ctrl_pkg::FUSE_AW,
    parameter int DW = misc_ctrl_pkg::FUSE_DW
);
    logic start;
    logic busy;
    logic done;
    logic pwr;
    logic rd;
    logic [AW-1:0] addr;
    logic [DW-1:0] data;
    logic load_valid;
    logic [AW-1:0] load_addr;
    logic [DW-1:0] load_data;

    modport ctrl (
        output start,
        output data,
        input busy,
        input done,
        input pwr,
        input rd,
        input addr,
        input load_valid,
        input load_addr,
        input load_data
    );

    modport seq (
        input start,
        input data,
        output busy,
        output done,
        output pwr,
        output rd,
        output addr,
        output load_valid,
        output load_addr,
        output load_data
    );
endinterface : fuse_seq_if

/* verilog/fuse_loader.sv */
// Fuse array reload sequencer: power up, settle, read every word, power down
`timescale 1ns/100ps
module fuse_loader #(
    parameter int WORDS = misc_ctrl_pkg::FUSE_WORDS,
    parameter int AW = misc_ctrl_pkg::FUSE_AW,
    parameter int DW = misc_ctrl_pkg::FUSE_DW,
    parameter int SETTLE_CYC = misc_ctrl_pkg::FUSE_SETTLE_CYC
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic nrst_i,
    // Sequencer link
    fuse_seq_if.seq bus
);

    typedef struct packed {
        misc_ctrl_pkg::fuse_state_e state;
        logic [7:0] cnt;
        logic [AW-1:0] addr;
        logic phase;
        logic pwr;
        logic rd;
        logic busy;
        logic done;
        logic load_valid;
        logic [AW-1:0] load_addr;
        logic [DW-1:0] load_data;
    } loader_s;

    loader_s st_reg;
    loader_s st_next;

    always_comb begin
        st_next = st_reg;
        st_next.rd = 1'b0;
        st_next.done = 1'b0;
        st_next.load_valid = 1'b0;
        case (st_reg.state)
            misc_ctrl_pkg::FS_OFF: begin
                if (bus.start) begin
                    st_next.pwr = 1'b1;
                    st_next.busy = 1'b1;
                    st_next.cnt = '0;
                    st_next.state = misc_ctrl_pkg::FS_SETTLE;
                end
            end
            misc_ctrl_pkg::FS_SETTLE: begin
                if (st_reg.cnt == 8'(SETTLE_CYC - 1)) begin
                    st_next.addr = '0;
                    st_next.phase = 1'b0;
                    st_next.state = misc_ctrl_pkg::FS_READ;
                end else begin
                    st_next.cnt = st_reg.cnt + 8'h01;
                end
            end
            misc_ctrl_pkg::FS_READ: begin
                if (!st_reg.phase) begin
                    st_next.rd = 1'b1;
                    st_next.phase = 1'b1;
                end else begin
                    // Copy one word into the register file
                    st_next.load_valid = 1'b1;
                    st_next.load_addr = st_reg.addr;
                    st_next.load_data = bus.data;
                    st_next.phase = 1'b0;
                    if (st_reg.addr == AW'(WORDS - 1)) begin
                        st_next.state = misc_ctrl_pkg::FS_DOWN;
                    end else begin
                        st_next.addr = st_reg.addr + AW'(1);
                    end
                end
            end
            misc_ctrl_pkg::FS_DOWN: begin
                st_next.pwr = 1'b0;
                st_next.busy = 1'b0;
                st_next.done = 1'b1;
                st_next.state = misc_ctrl_pkg::FS_OFF;
            end
            default: begin
                st_next = '0;
            end
        endcase
    end

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign bus.busy = st_reg.busy;
    assign bus.done = st_reg.done;
    assign bus.pwr = st_reg.pwr;
    assign bus.rd = st_reg.rd;
    assign bus.addr = st_reg.addr;
    assign bus.load_valid = st_reg.load_valid;
    assign bus.load_addr = st_reg.load_addr;
    assign bus.load_data = st_reg.load_data;

endmodule : fuse_loader

/* verilog/sensor_misc_control_regs.sv */
// Miscellaneous control registers: init, spare, power levels, axis drive tests, restart
//
// Notes on behaviour
// - The spare register reads back the last written byte and steers nothing.
// - Power setting bits 2:0 choose low, ultra-low or precision power for the active modes.
// - Power setting bits 6:4 choose the same levels for the activity-watch mode.
// - The serial fast enable bit always reads zero, so software tracks it itself.
// - X drive bit 2 pushes the element positive and bit 3 negative, both zero at reset.
// - Y drive reads bit 7 set in watch, active and one-shot modes and clear in sleep or standby.
// - Y drive bit 2 pushes the element positive and bit 3 negative, both off at reset.
// - Z drive bit 2 pushes positive and bit 3 negative; software writes the rest as zero.
// - Restart bit 6 defaults registers, reloads fuses, expands offsets and clears itself.
// - Any reset or restart returns the serial port from 3-wire to 4-wire operation.
// - Reload bit 7 powers the fuse array, copies it all, powers it down; software clears it.
// - The busy flag shows fuse reload progress until the copy is finished.
`timescale 1ns/100ps
module sensor_misc_control_regs #(
    parameter int FUSE_WORDS = misc_ctrl_pkg::FUSE_WORDS,
    parameter int FUSE_AW = misc_ctrl_pkg::FUSE_AW,
    parameter int FUSE_SETTLE_CYC = misc_ctrl_pkg::FUSE_SETTLE_CYC
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic nrst_i,
    // Serial register port
    input wire logic [7:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [7:0] reg_rdata_o,
    output logic reg_rvalid_o,
    // Operating mode and serial configuration
    input wire logic [2:0] op_mode_field_i,
    input wire logic three_wire_set_i,
    output logic serial_three_wire_o,
    output logic serial_fast_enable_o,
    // Power levels
    output logic [2:0] active_power_level_o,
    output logic [2:0] watch_power_level_o,
    // Axis drive
    output logic x_push_positive_o,
    output logic x_push_negative_o,
    output logic y_push_positive_o,
    output logic y_push_negative_o,
    output logic z_push_positive_o,
    output logic z_push_negative_o,
    // Restart sequence
    output logic defaults_load_o,
    output logic auto_offset_data_expand_o,
    output logic fuse_busy_o,
    // Fuse array
    output logic fuse_pwr_o,
    output logic fuse_rd_o,
    output logic [FUSE_AW-1:0] fuse_addr_o,
    input wire logic [7:0] fuse_data_i,
    output logic fuse_load_valid_o,
    output logic [FUSE_AW-1:0] fuse_load_addr_o,
    output logic [7:0] fuse_load_data_o
);

    typedef struct packed {
        misc_ctrl_pkg::restart_state_e state;
        logic restart_bit;
        logic reload_bit;
        logic fuse_start;
        logic defaults_pulse;
        logic expand_pulse;
        logic [7:0] init_word_three;
        logic [7:0] spare_storage;
        logic [2:0] active_raw;
        logic [2:0] watch_raw;
        logic [2:0] active_lvl;
        logic [2:0] watch_lvl;
        logic fast_en;
        logic x_pos;
        logic x_neg;
        logic y_pos;
        logic y_neg;
        logic z_pos;
        logic z_neg;
        logic three_wire;
        logic [7:0] rdata;
        logic rvalid;
    } ctrl_s;

    ctrl_s st_reg;
    ctrl_s st_next;

    fuse_seq_if #(.AW(FUSE_AW), .DW(misc_ctrl_pkg::FUSE_DW)) fuse_bus ();

    fuse_loader #(
        .WORDS(FUSE_WORDS),
        .AW(FUSE_AW),
        .DW(misc_ctrl_pkg::FUSE_DW),
        .SETTLE_CYC(FUSE_SETTLE_CYC)
    ) u_fuse_loader (
        .clk_i(clk_i),
        .nrst_i(nrst_i),
        .bus(fuse_bus.seq)
    );

    assign fuse_bus.start = st_reg.fuse_start;
    assign fuse_bus.data = fuse_data_i;

    // Reserved codes fall back to low power
    function automatic logic [2:0] level_decode(input logic [2:0] code);
        logic [2:0] lvl;
        case (code)
            misc_ctrl_pkg::PWR_ULTRA: lvl = misc_ctrl_pkg::PWR_ULTRA;
            misc_ctrl_pkg::PWR_PRECISE: lvl = misc_ctrl_pkg::PWR_PRECISE;
            default: lvl = misc_ctrl_pkg::PWR_LOW;
        endcase
        return lvl;
    endfunction : level_decode

    logic mode_active;
    logic seq_idle;
    logic [7:0] rd_word;

    assign mode_active = (op_mode_field_i != misc_ctrl_pkg::OP_SLEEP)
                         && (op_mode_field_i != misc_ctrl_pkg::OP_STANDBY);
    assign seq_idle = (st_reg.state == misc_ctrl_pkg::RS_IDLE);

    // Read multiplexer
    always_comb begin
        rd_word = misc_ctrl_pkg::REG_RESET;
        case (reg_addr_i)
            misc_ctrl_pkg::ADDR_INIT3: begin
                rd_word = st_reg.init_word_three;
            end
            misc_ctrl_pkg::ADDR_SPARE: begin
                rd_word = st_reg.spare_storage;
            end
            misc_ctrl_pkg::ADDR_POWER: begin
                rd_word[misc_ctrl_pkg::ACTIVE_LVL_LSB +: misc_ctrl_pkg::LVL_W] = st_reg.active_raw;
                rd_word[misc_ctrl_pkg::WATCH_LVL_LSB +: misc_ctrl_pkg::LVL_W] = st_reg.watch_raw;
                rd_word[misc_ctrl_pkg::BIT_FAST] = 1'b0;
            end
            misc_ctrl_pkg::ADDR_YDRV: begin
                rd_word[misc_ctrl_pkg::BIT_Y_ACTIVE] = mode_active;
                rd_word[misc_ctrl_pkg::BIT_PUSH_POS] = st_reg.y_pos;
                rd_word[misc_ctrl_pkg::BIT_PUSH_NEG] = st_reg.y_neg;
            end
            misc_ctrl_pkg::ADDR_ZDRV: begin
                rd_word[misc_ctrl_pkg::BIT_PUSH_POS] = st_reg.z_pos;
                rd_word[misc_ctrl_pkg::BIT_PUSH_NEG] = st_reg.z_neg;
            end
            misc_ctrl_pkg::ADDR_RESTART: begin
                rd_word[misc_ctrl_pkg::BIT_RESTART] = st_reg.restart_bit;
                rd_word[misc_ctrl_pkg::BIT_RELOAD] = st_reg.reload_bit;
            end
            default: begin
                rd_word = misc_ctrl_pkg::REG_RESET;
            end
        endcase
    end

    always_comb begin
        st_next = st_reg;
        st_next.fuse_start = 1'b0;
        st_next.defaults_pulse = 1'b0;
        st_next.expand_pulse = 1'b0;
        st_next.rvalid = reg_rd_i;
        if (reg_rd_i) begin
            st_next.rdata = rd_word;
        end

        // Serial port width request from the port configuration
        if (three_wire_set_i) begin
            st_next.three_wire = 1'b1;
        end

        // Register writes, ignored while defaults are being restored
        if (reg_wr_i && (st_reg.state != misc_ctrl_pkg::RS_DEFAULTS)) begin
            case (reg_addr_i)
                misc_ctrl_pkg::ADDR_INIT3: begin
                    st_next.init_word_three = reg_wdata_i;
                end
                misc_ctrl_pkg::ADDR_SPARE: begin
                    st_next.spare_storage = reg_wdata_i;
                end
                misc_ctrl_pkg::ADDR_POWER: begin
                    st_next.active_raw =
                        reg_wdata_i[misc_ctrl_pkg::ACTIVE_LVL_LSB +: misc_ctrl_pkg::LVL_W];
                    st_next.watch_raw =
                        reg_wdata_i[misc_ctrl_pkg::WATCH_LVL_LSB +: misc_ctrl_pkg::LVL_W];
                    st_next.active_lvl = level_decode(
                        reg_wdata_i[misc_ctrl_pkg::ACTIVE_LVL_LSB +: misc_ctrl_pkg::LVL_W]);
                    st_next.watch_lvl = level_decode(
                        reg_wdata_i[misc_ctrl_pkg::WATCH_LVL_LSB +: misc_ctrl_pkg::LVL_W]);
                    st_next.fast_en = reg_wdata_i[misc_ctrl_pkg::BIT_FAST];
                end
                misc_ctrl_pkg::ADDR_XDRV: begin
                    st_next.x_pos = reg_wdata_i[misc_ctrl_pkg::BIT_PUSH_POS];
                    st_next.x_neg = reg_wdata_i[misc_ctrl_pkg::BIT_PUSH_NEG];
                end
                misc_ctrl_pkg::ADDR_YDRV: begin
                    st_next.y_pos = reg_wdata_i[misc_ctrl_pkg::BIT_PUSH_POS];
                    st_next.y_neg = reg_wdata_i[misc_ctrl_pkg::BIT_PUSH_NEG];
                end
                misc_ctrl_pkg::ADDR_ZDRV: begin
                    st_next.z_pos = reg_wdata_i[misc_ctrl_pkg::BIT_PUSH_POS];
                    st_next.z_neg = reg_wdata_i[misc_ctrl_pkg::BIT_PUSH_NEG];
                end
                misc_ctrl_pkg::ADDR_RESTART: begin
                    st_next.reload_bit = reg_wdata_i[misc_ctrl_pkg::BIT_RELOAD];
                    if (seq_idle && reg_wdata_i[misc_ctrl_pkg::BIT_RESTART]) begin
                        st_next.restart_bit = 1'b1;
                        st_next.state = misc_ctrl_pkg::RS_DEFAULTS;
                    end else if (seq_idle && !fuse_bus.busy
                                 && reg_wdata_i[misc_ctrl_pkg::BIT_RELOAD]
                                 && !st_reg.reload_bit) begin
                        st_next.fuse_start = 1'b1;
                        st_next.state = misc_ctrl_pkg::RS_FUSE;
                    end
                end
                default: begin
                end
            endcase
        end

        // Restart and reload sequencing
        case (st_reg.state)
            misc_ctrl_pkg::RS_IDLE: begin
            end
            misc_ctrl_pkg::RS_DEFAULTS: begin
                st_next.init_word_three = misc_ctrl_pkg::REG_RESET;
                st_next.spare_storage = misc_ctrl_pkg::REG_RESET;
                st_next.active_raw = misc_ctrl_pkg::LVL_RESET;
                st_next.watch_raw = misc_ctrl_pkg::LVL_RESET;
                st_next.active_lvl = misc_ctrl_pkg::PWR_LOW;
                st_next.watch_lvl = misc_ctrl_pkg::PWR_LOW;
                st_next.fast_en = 1'b0;
                st_next.x_pos = 1'b0;
                st_next.x_neg = 1'b0;
                st_next.y_pos = 1'b0;
                st_next.y_neg = 1'b0;
                st_next.z_pos = 1'b0;
                st_next.z_neg = 1'b0;
                st_next.reload_bit = 1'b0;
                st_next.three_wire = 1'b0;
                st_next.defaults_pulse = 1'b1;
                if (!fuse_bus.busy) begin
                    st_next.fuse_start = 1'b1;
                    st_next.state = misc_ctrl_pkg::RS_FUSE;
                end
            end
            misc_ctrl_pkg::RS_FUSE: begin
                if (fuse_bus.done) begin
                    st_next.state = st_reg.restart_bit ? misc_ctrl_pkg::RS_EXPAND
                                                       : misc_ctrl_pkg::RS_IDLE;
                end
            end
            misc_ctrl_pkg::RS_EXPAND: begin
                st_next.expand_pulse = 1'b1;
                st_next.restart_bit = 1'b0;
                st_next.state = misc_ctrl_pkg::RS_IDLE;
            end
            default: begin
                st_next.state = misc_ctrl_pkg::RS_IDLE;
            end
        endcase
    end

    // Power-on reset leaves the port in 4-wire mode
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign reg_rdata_o = st_reg.rdata;
    assign reg_rvalid_o = st_reg.rvalid;
    assign serial_three_wire_o = st_reg.three_wire;
    assign serial_fast_enable_o = st_reg.fast_en;
    assign active_power_level_o = st_reg.active_lvl;
    assign watch_power_level_o = st_reg.watch_lvl;
    assign x_push_positive_o = st_reg.x_pos;
    assign x_push_negative_o = st_reg.x_neg;
    assign y_push_positive_o = st_reg.y_pos;
    assign y_push_negative_o = st_reg.y_neg;
    assign z_push_positive_o = st_reg.z_pos;
    assign z_push_negative_o = st_reg.z_neg;
    assign defaults_load_o = st_reg.defaults_pulse;
    assign auto_offset_data_expand_o = st_reg.expand_pulse;
    assign fuse_busy_o = fuse_bus.busy;
    assign fuse_pwr_o = fuse_bus.pwr;
    assign fuse_rd_o = fuse_bus.rd;
    assign fuse_addr_o = fuse_bus.addr;
    assign fuse_load_valid_o = fuse_bus.load_valid;
    assign fuse_load_addr_o = fuse_bus.load_addr;
    assign fuse_load_data_o = fuse_bus.load_data;

endmodule : sensor_misc_control_regs

/* tb/misc_ctrl_sva.sv */
// Concurrent checks on the ports of the miscellaneous control registers
`timescale 1ns/100ps
module misc_ctrl_sva (
    // Clock and reset
    input wire logic clk_i,
    input wire logic nrst_i,
    // Register port
    input wire logic [7:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [7:0] reg_rdata_o,
    input wire logic reg_rvalid_o,
    // Mode and serial width
    input wire logic [2:0] op_mode_field_i,
    input wire logic serial_three_wire_o,
    // Levels and pushes
    input wire logic [2:0] active_power_level_o,
    input wire logic [2:0] watch_power_level_o,
    input wire logic x_push_positive_o,
    input wire logic x_push_negative_o,
    input wire logic z_push_positive_o,
    input wire logic z_push_negative_o,
    // Restart and fuse
    input wire logic defaults_load_o,
    input wire logic auto_offset_data_expand_o,
    input wire logic fuse_busy_o,
    input wire logic fuse_pwr_o,
    input wire logic fuse_rd_o,
    input wire logic fuse_load_valid_o
);
    logic rst_wr_reg;
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            rst_wr_reg <= 1'b0;
        end else begin
            rst_wr_reg <= reg_wr_i && reg_addr_i == 8'h24 && reg_wdata_i[6];
        end
    end
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!nrst_i);

    rvalid_timing_a:
        assert property (reg_rvalid_o == $past(reg_rd_i))
        else $error("read valid misplaced");
    fast_reads_zero_a:
        assert property (reg_rd_i && reg_addr_i == 8'h1C |=> !reg_rdata_o[7])
        else $error("fast enable read as one");
    y_mode_read_a:
        assert property (reg_rd_i && reg_addr_i == 8'h21 |=>
            reg_rdata_o[7] == ($past(op_mode_field_i) > 3'h1))
        else $error("y drive mode bit wrong");
    x_push_follow_a:
        assert property (reg_wr_i && reg_addr_i == 8'h20 && !rst_wr_reg |=>
            {x_push_negative_o, x_push_positive_o} == $past(reg_wdata_i[3:2]))
        else $error("x push wrong");
    z_push_cause_a:
        assert property ($changed({z_push_negative_o, z_push_positive_o}) |->
            $past(reg_wr_i && reg_addr_i == 8'h22) || defaults_load_o)
        else $error("z push changed alone");
    active_level_a:
        assert property (reg_wr_i && reg_addr_i == 8'h1C && !rst_wr_reg |=>
            active_power_level_o == ($past(reg_wdata_i[2:0]) inside {3'h3, 3'h4} ?
            $past(reg_wdata_i[2:0]) : 3'h0))
        else $error("active level wrong");
    watch_level_a:
        assert property (reg_wr_i && reg_addr_i == 8'h1C && !rst_wr_reg |=>
            watch_power_level_o == ($past(reg_wdata_i[6:4]) inside {3'h3, 3'h4} ?
            $past(reg_wdata_i[6:4]) : 3'h0))
        else $error("watch level wrong");
    restart_clears_a:
        assert property (defaults_load_o |-> !serial_three_wire_o && !x_push_positive_o
            && active_power_level_o == 3'h0 ##1 !defaults_load_o [*2]
            ##[1:1000] auto_offset_data_expand_o)
        else $error("restart sequence wrong");
    busy_power_a:
        assert property (fuse_busy_o == fuse_pwr_o)
        else $error("busy and power differ");
    copy_under_busy_a:
        assert property (fuse_rd_o |=> fuse_load_valid_o && fuse_busy_o)
        else $error("word read not copied");
endmodule : misc_ctrl_sva

bind sensor_misc_control_regs misc_ctrl_sva u_misc_ctrl_sva (
    .clk_i, .nrst_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o,
    .reg_rvalid_o, .op_mode_field_i, .serial_three_wire_o, .active_power_level_o,
    .watch_power_level_o, .x_push_positive_o, .x_push_negative_o, .z_push_positive_o,
    .z_push_negative_o, .defaults_load_o, .auto_offset_data_expand_o, .fuse_busy_o,
    .fuse_pwr_o, .fuse_rd_o, .fuse_load_valid_o
);

/* tb/fuse_array_model.sv */
// Behavioural fuse array: a word stands from mid read cycle to mid next cycle
`timescale 1ns/100ps
module fuse_array_model (
    // Clock
    input wire logic clk_i,
    // Array access
    input wire logic pwr_i,
    input wire logic rd_i,
    input wire logic [4:0] addr_i,
    output logic [7:0] data_o
);
    initial data_o = 8'h5A;
    // Driven off the falling edge so the word is settled at the capturing edge
    always @(negedge clk_i) begin
        if (pwr_i && rd_i) begin
            data_o <= 8'hA0 ^ {3'h0, addr_i};
        end else begin
            data_o <= ~data_o;
        end
    end
endmodule : fuse_array_model

/* tb/tb.sv */
// Self-checking testbench for the miscellaneous control registers
`timescale 1ns/100ps
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin fail_count++; \
    $display("Error %0t got %h exp %h", $time, g, e); end end
module tb;
    logic clk_i, nrst_i, wr, rd, tws, rv, tw, fe, xp, xn, yp, yn, zp, zn, dl, ax, bz, pw, fr, lv;
    logic [7:0] ad, wd, rdat, fd, ld;
    logic [2:0] om, apl, wpl;
    logic [4:0] fa, la;
    int fail_count = 0;
    int compares = 0;

    sensor_misc_control_regs #(.FUSE_WORDS(4), .FUSE_SETTLE_CYC(1)) u_sensor_misc_control_regs (
        .clk_i, .nrst_i, .reg_addr_i(ad), .reg_wdata_i(wd), .reg_wr_i(wr), .reg_rd_i(rd),
        .reg_rdata_o(rdat), .reg_rvalid_o(rv), .op_mode_field_i(om), .three_wire_set_i(tws),
        .serial_three_wire_o(tw), .serial_fast_enable_o(fe), .active_power_level_o(apl),
        .watch_power_level_o(wpl), .x_push_positive_o(xp), .x_push_negative_o(xn),
        .y_push_positive_o(yp), .y_push_negative_o(yn), .z_push_positive_o(zp),
        .z_push_negative_o(zn), .defaults_load_o(dl), .auto_offset_data_expand_o(ax),
        .fuse_busy_o(bz), .fuse_pwr_o(pw), .fuse_rd_o(fr), .fuse_addr_o(fa),
        .fuse_data_i(fd), .fuse_load_valid_o(lv), .fuse_load_addr_o(la), .fuse_load_data_o(ld)
    );
    fuse_array_model u_fuse_array_model (
        .clk_i, .pwr_i(pw), .rd_i(fr), .addr_i(fa), .data_o(fd)
    );

    initial begin
        clk_i = 1'b0;
        forever #50 clk_i = ~clk_i;
    end

    task automatic wreg(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk_i);
        ad = a;
        wd = d;
        wr = 1'b1;
        @(negedge clk_i);
        wr = 1'b0;
    endtask : wreg

    task automatic rreg(input logic [7:0] a, input logic [7:0] e);
        @(negedge clk_i);
        ad = a;
        rd = 1'b1;
        @(negedge clk_i);
        rd = 1'b0;
        `CHK(rv, 1'b1)
        `CHK(rdat, e)
    endtask : rreg

    task automatic pulse_three_wire();
        @(negedge clk_i);
        tws = 1'b1;
        @(negedge clk_i);
        tws = 1'b0;
        `CHK(tw, 1'b1)
    endtask : pulse_three_wire

    task automatic t_reset();
        logic [7:0] a [8] = '{8'h1A, 8'h1B, 8'h1C, 8'h20, 8'h21, 8'h22, 8'h24, 8'h30};
        `CHK({tw, apl, wpl, xp, xn, bz}, 10'h000)
        wreg(8'h1A, 8'h00);
        foreach (a[i]) rreg(a[i], 8'h00);
    endtask : t_reset

    task automatic t_spare();
        wreg(8'h1B, 8'hA5);
        wreg(8'h30, 8'h3C);
        rreg(8'h1B, 8'hA5);
        rreg(8'h30, 8'h00);
        wreg(8'h1B, 8'h5A);
        rreg(8'h1B, 8'h5A);
        `CHK({apl, wpl, xp, zp}, 8'h00)
    endtask : t_spare

    task automatic t_power();
        logic [2:0] c;
        logic [2:0] w;
        for (int k = 0; k < 8; k++) begin
            c = 3'(k);
            w = 3'(7 - k);
            wreg(8'h1C, {1'b1, w, 1'b1, c});
            `CHK(apl, (c == 3'h3 || c == 3'h4) ? c : 3'h0)
            `CHK(wpl, (w == 3'h3 || w == 3'h4) ? w : 3'h0)
            `CHK(fe, 1'b1)
            rreg(8'h1C, {1'b0, w, 1'b0, c});
        end
        wreg(8'h1C, 8'h00);
        `CHK(fe, 1'b0)
    endtask : t_power

    task automatic t_drive();
        logic [1:0] p;
        for (int k = 0; k < 4; k++) begin
            p = 2'(k);
            wreg(8'h20, {4'h0, p, 2'h1});
            wreg(8'h21, {4'h8, p, 2'h0});
            wreg(8'h22, {4'h0, ~p, 2'h0});
            `CHK({xn, xp, yn, yp, zn, zp}, {p, p, ~p})
            rreg(8'h20, 8'h00);
            rreg(8'h22, {4'h0, ~p, 2'h0});
            for (int m = 0; m < 8; m++) begin
                om = 3'(m);
                rreg(8'h21, {m > 1, 3'h0, p, 2'h0});
            end
        end
        om = 3'h0;
    endtask : t_drive

    task automatic t_reload();
        int n;
        n = 0;
        pulse_three_wire();
        wreg(8'h24, 8'h80);
        for (int i = 0; i < 60 && (n == 0 || bz); i++) begin
            @(negedge clk_i);
            if (lv) begin
                n++;
                `CHK({bz, ld}, {1'b1, 8'hA0 ^ {3'h0, la}})
            end
        end
        `CHK(n, 4)
        `CHK({bz, pw}, 2'h0)
        rreg(8'h24, 8'h80);
        wreg(8'h24, 8'h00);
        rreg(8'h24, 8'h00);
    endtask : t_reload

    task automatic t_restart();
        wreg(8'h1B, 8'h77);
        wreg(8'h1C, 8'h43);
        wreg(8'h22, 8'h08);
        wreg(8'h20, 8'h05);
        wreg(8'h24, 8'h40);
        rreg(8'h24, 8'h40);
        for (int i = 0; i < 60 && !ax; i++) @(negedge clk_i);
        `CHK(ax, 1'b1)
        `CHK({tw, apl, wpl, xp, zn, bz}, 10'h000)
        rreg(8'h1B, 8'h00);
        rreg(8'h24, 8'h00);
    endtask : t_restart

    task automatic give_verdict();
        $display("compares %0d fail_count %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : give_verdict

    initial begin
        #(3000 * 100);
        fail_count++;
        give_verdict();
    end

    initial begin
        nrst_i = 1'b0;
        {wr, rd, tws} = 3'h0;
        ad = 8'h00;
        wd = 8'h00;
        om = 3'h0;
        repeat (5) @(negedge clk_i);
        nrst_i = 1'b1;
        t_reset();
        t_spare();
        t_power();
        t_drive();
        pulse_three_wire();
        t_reload();
        pulse_three_wire();
        t_restart();
        give_verdict();
    end
endmodule : tb
